// ===== pkg/fpa_pkg.sv
// Shared constants and types for the floating-point seed/min/max/clip unit.
// Assumes 32-bit single-precision operands and a 32-bit AXI4-Lite register bus.
package fpa_pkg;

    // ==========================================================
    // Register map, byte addresses
    localparam int          ADDR_W      = 5;
    localparam int          DATA_W      = 32;
    localparam logic [4:0]  ADDR_OPA    = 5'h00;
    localparam logic [4:0]  ADDR_OPB    = 5'h04;
    localparam logic [4:0]  ADDR_CMD    = 5'h08;
    localparam logic [4:0]  ADDR_RESULT = 5'h0C;
    localparam logic [4:0]  ADDR_ASTAT  = 5'h10;
    localparam logic [4:0]  ADDR_STKY   = 5'h14;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int          CMD_OP_LSB  = 0;
    localparam int          CMD_OP_W    = 3;

    // ==========================================================
    // Float encodings
    localparam logic [7:0]  EXP_ZERO    = 8'h00;
    localparam logic [7:0]  EXP_ALL1    = 8'hFF;
    localparam logic [8:0]  EXP_BIAS    = 9'h07F;
    localparam logic [22:0] MAN_ZERO    = 23'h000000;
    localparam logic [30:0] MAG_ZERO    = 31'h00000000;
    localparam logic [31:0] ALL_ONES    = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_ZERO   = 32'h00000000;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        OP_RECIP_SQRT_SEED,
        OP_SIGN_COPY,
        OP_MIN,
        OP_MAX,
        OP_CLIP
    } fpa_op_e;

    typedef struct packed {
        logic        sign;
        logic [7:0]  exp;
        logic [22:0] man;
    } fpa_float_s;

    typedef struct packed {
        logic alu_invalid_flag;
        logic alu_sign_flag;
        logic alu_carry_flag;
        logic alu_overflow_flag;
        logic alu_negative_flag;
        logic alu_zero_flag;
    } fpa_arith_flags_s;

    typedef struct packed {
        logic sticky_invalid_bit;
        logic sticky_fixed_overflow_bit;
        logic sticky_overflow_bit;
        logic sticky_underflow_bit;
    } fpa_sticky_flags_s;

    localparam logic [5:0]  ASTAT_RESET = 6'h00;
    localparam logic [3:0]  STKY_RESET  = 4'h0;

endpackage

// ===== rtl/fpa_rsqrt_seed.sv
// Combinational reciprocal-square-root seed with its result flags.
// Assumes a single-precision operand; the caller registers the outputs.
`timescale 1ns/100ps
module fpa_rsqrt_seed #(
    parameter int SEED_W = 4
) (
    input  wire fpa_pkg::fpa_float_s       operand,
    output fpa_pkg::fpa_float_s            result,
    output fpa_pkg::fpa_arith_flags_s      flags
);

    // ==========================================================
    // Seed table, rounded to nearest at each bin centre
    localparam int ROM_DEPTH = 128;
    localparam int HALF      = 64;
    localparam int SCALE     = 131072;

    function automatic logic [ROM_DEPTH*SEED_W-1:0] build_rom();
        logic [ROM_DEPTH*SEED_W-1:0] t;
        int                          f;
        t = '0;
        for (int i = 0; i < ROM_DEPTH; i++) begin
            f = 0;
            for (int g = 0; g < (1 << SEED_W) - 1; g++) begin
                if ((33 + 2 * g) * (33 + 2 * g) * (129 + 2 * (i % HALF))
                    <= ((i >= HALF) ? 4 : 2) * SCALE) begin
                    f = g + 1;
                end
            end
            t[i*SEED_W +: SEED_W] = SEED_W'(f);
        end
        return t;
    endfunction

    localparam logic [ROM_DEPTH*SEED_W-1:0] ROM = build_rom();

    // RQ2: exponent LSB joined to mantissa MSBs
    wire [6:0]        rom_idx  = {operand.exp[0], operand.man[22:17]};
    // RQ1: four-bit seed mantissa
    wire [SEED_W-1:0] seed_man = ROM[rom_idx*SEED_W +: SEED_W];

    // RQ3: floor half, negate, decrement; odd exponents pair with root-two table half
    wire [8:0] unb_exp  = {1'b0, operand.exp} - fpa_pkg::EXP_BIAS;
    wire [8:0] half_exp = 9'($signed(unb_exp) >>> 1);
    wire [8:0] neg_exp  = 9'(-half_exp);
    wire [8:0] seed_exp = neg_exp - 9'h001 + fpa_pkg::EXP_BIAS;

    // Denormals count as zero, so they also give infinity
    wire is_zero = (operand.exp == fpa_pkg::EXP_ZERO);
    wire is_inf  = (operand.exp == fpa_pkg::EXP_ALL1) && (operand.man == fpa_pkg::MAN_ZERO);
    wire is_nan  = (operand.exp == fpa_pkg::EXP_ALL1) && (operand.man != fpa_pkg::MAN_ZERO);
    // RQ7: negative nonzero or NaN is invalid
    wire bad_in  = is_nan | (operand.sign & ~is_zero);

    // RQ4: signed infinity for zero, sign carried through
    // RQ5: +inf gives +0, invalid input all ones
    assign result = bad_in  ? fpa_pkg::ALL_ONES :
                    is_zero ? {operand.sign, fpa_pkg::EXP_ALL1, fpa_pkg::MAN_ZERO} :
                    is_inf  ? fpa_pkg::WORD_ZERO :
                    {operand.sign, seed_exp[7:0], seed_man, {(23 - SEED_W){1'b0}}};

    // RQ6: zero, negative and overflow per operand class
    assign flags = '{alu_invalid_flag  : bad_in,
                     alu_sign_flag     : 1'b0,
                     alu_carry_flag    : 1'b0,
                     alu_overflow_flag : is_zero,
                     alu_negative_flag : is_zero & operand.sign,
                     alu_zero_flag     : is_inf & ~operand.sign};

endmodule

// ===== rtl/fpa_cmp_unit.sv
// Combinational sign-copy, minimum, maximum and clip with result flags.
// Assumes single-precision operands; the caller registers the outputs.
`timescale 1ns/100ps
module fpa_cmp_unit (
    input  wire fpa_pkg::fpa_op_e          op,
    input  wire fpa_pkg::fpa_float_s       opa,
    input  wire fpa_pkg::fpa_float_s       opb,
    output fpa_pkg::fpa_float_s            result,
    output fpa_pkg::fpa_arith_flags_s      flags
);

    // ==========================================================
    // RQ10: flush denormals to signed zero
    // RQ14: same flush ahead of every compare
    wire [31:0] fa = (opa.exp == fpa_pkg::EXP_ZERO) ? {opa.sign, fpa_pkg::MAG_ZERO} : opa;
    wire [31:0] fb = (opb.exp == fpa_pkg::EXP_ZERO) ? {opb.sign, fpa_pkg::MAG_ZERO} : opb;
    wire a_nan = (opa.exp == fpa_pkg::EXP_ALL1) && (opa.man != fpa_pkg::MAN_ZERO);
    wire b_nan = (opb.exp == fpa_pkg::EXP_ALL1) && (opb.man != fpa_pkg::MAN_ZERO);
    wire any_nan = a_nan | b_nan;

    // Ordered keys put -0 just below +0
    wire [31:0] ka = fa[31] ? ~fa : {1'b1, fa[30:0]};
    wire [31:0] kb = fb[31] ? ~fb : {1'b1, fb[30:0]};
    wire a_lt_b = (ka < kb);
    wire mag_lt = (fa[30:0] < fb[30:0]);

    // RQ9: second sign onto first magnitude
    wire [31:0] copy_w = {fb[31], fa[30:0]};
    // RQ11: smaller, -0 wins tie of zeros
    wire [31:0] min_w  = a_lt_b ? fa : fb;
    // RQ12: larger, +0 wins tie of zeros
    wire [31:0] max_w  = a_lt_b ? fb : fa;
    // RQ13: pass or limit to second magnitude
    wire [31:0] clip_w = mag_lt ? fa : {fa[31], fb[30:0]};

    logic [31:0] sel_w;
    always_comb begin
        unique case (op)
            fpa_pkg::OP_SIGN_COPY: sel_w = copy_w;
            fpa_pkg::OP_MIN:       sel_w = min_w;
            fpa_pkg::OP_MAX:       sel_w = max_w;
            fpa_pkg::OP_CLIP:      sel_w = clip_w;
            default:               sel_w = copy_w;
        endcase
    end

    // RQ14: any NaN gives all ones
    assign result = any_nan ? fpa_pkg::ALL_ONES : sel_w;

    // RQ15: zero and negative from result
    // RQ16: invalid on any NaN
    assign flags = '{alu_invalid_flag  : any_nan,
                     alu_sign_flag     : 1'b0,
                     alu_carry_flag    : 1'b0,
                     alu_overflow_flag : 1'b0,
                     alu_negative_flag : result.sign,
                     alu_zero_flag     : (result[30:0] == fpa_pkg::MAG_ZERO)};

endmodule

// ===== rtl/fpa_alu.sv
// Top of the floating-point seed/min/max/clip unit with AXI4-Lite registers.
// Assumes the bus master shares CLK and RST and keeps one write and one
// read outstanding at most.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps

// Overview of operation
// RQ1: The seed approximates one over the square root of the operand to four bits.
// RQ2: The seed mantissa is read from a table indexed by exponent LSB and six mantissa MSBs.
// RQ3: The seed exponent is minus the halved operand exponent, minus one.
// RQ4: The seed keeps the operand sign and a zero operand gives same-signed infinity.
// RQ5: Plus infinity gives plus zero while NaN or negative nonzero gives all ones.
// RQ6: Seed flags set zero for +0 result, negative for -0 in, overflow for zero in.
// RQ7: Seed invalid flag marks a negative nonzero or NaN operand.
// RQ8: Seed sets sticky overflow and invalid from its flags and leaves the rest alone.
// RQ9: Sign copy puts the second sign on the first operand's exponent and mantissa.
// RQ10: Sign copy treats denormals as signed zero and gives all ones on NaN.
// RQ11: Minimum returns the smaller operand and -0 for a mix of zeros.
// RQ12: Maximum returns the larger operand and +0 for a mix of zeros.
// RQ13: Clip passes the first when smaller in magnitude, else limits with its sign.
// RQ14: Minimum, maximum and clip flush denormals and give all ones on NaN.
// RQ15: Compare ops flag zero and negative from the result and clear the rest.
// RQ16: Compare ops flag and stick invalid on any NaN and leave other sticky bits.
// RQ17: Sticky bits hold until software clears them; flags rewrite each operation.
module fpa_alu (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic [fpa_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic [2:0]                 S_AXI_AWPROT,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [fpa_pkg::DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    output logic [1:0]                      S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    input  wire logic [fpa_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic [2:0]                 S_AXI_ARPROT,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    output logic [fpa_pkg::DATA_W-1:0]      S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    output fpa_pkg::fpa_arith_flags_s       ARITH_STATUS_FLAGS,
    output fpa_pkg::fpa_sticky_flags_s      STICKY_STATUS_FLAGS
);

    // ==========================================================
    // Write channel capture
    logic                       awready_r;
    logic                       wready_r;
    logic                       aw_have_r;
    logic                       w_have_r;
    logic [fpa_pkg::ADDR_W-1:0] waddr_r;
    logic [fpa_pkg::DATA_W-1:0] wdata_r;
    logic [3:0]                 wstrb_r;
    logic                       bvalid_r;
    logic [1:0]                 bresp_r;

    wire aw_hs    = S_AXI_AWVALID & awready_r;
    wire w_hs     = S_AXI_WVALID & wready_r;
    wire b_hs     = bvalid_r & S_AXI_BREADY;
    wire do_write = aw_have_r & w_have_r & ~bvalid_r;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            waddr_r   <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            if (aw_hs) begin
                awready_r <= 1'b0;
                aw_have_r <= 1'b1;
                waddr_r   <= S_AXI_AWADDR;
            end
            if (w_hs) begin
                wready_r <= 1'b0;
                w_have_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
            // Reopen only after the response, one write at a time
            if (b_hs) begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Write decode
    wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                             {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [fpa_pkg::ADDR_W-1:0] waddr_al = {waddr_r[fpa_pkg::ADDR_W-1:2], 2'b00};
    wire wr_opa    = do_write & (waddr_al == fpa_pkg::ADDR_OPA);
    wire wr_opb    = do_write & (waddr_al == fpa_pkg::ADDR_OPB);
    wire wr_cmd    = do_write & (waddr_al == fpa_pkg::ADDR_CMD) & wstrb_r[0];
    wire wr_stky   = do_write & (waddr_al == fpa_pkg::ADDR_STKY) & wstrb_r[0];
    wire wr_ro     = (waddr_al == fpa_pkg::ADDR_RESULT) | (waddr_al == fpa_pkg::ADDR_ASTAT);
    wire wr_known  = (waddr_al == fpa_pkg::ADDR_OPA) | (waddr_al == fpa_pkg::ADDR_OPB) |
                     (waddr_al == fpa_pkg::ADDR_CMD) | (waddr_al == fpa_pkg::ADDR_STKY) |
                     wr_ro;
    wire [fpa_pkg::CMD_OP_W-1:0] cmd_code = wdata_r[fpa_pkg::CMD_OP_LSB +: fpa_pkg::CMD_OP_W];
    // Codes past the last operation are dropped without effect
    wire cmd_legal = (cmd_code <= fpa_pkg::OP_CLIP);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_r <= 1'b0;
            bresp_r  <= fpa_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? fpa_pkg::RESP_OKAY : fpa_pkg::RESP_SLVERR;
        end else if (b_hs) begin
            bvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Operand registers and launch
    fpa_pkg::fpa_float_s opa_r;
    fpa_pkg::fpa_float_s opb_r;
    fpa_pkg::fpa_op_e    op_r;
    logic                go_r;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            opa_r <= fpa_pkg::WORD_ZERO;
            opb_r <= fpa_pkg::WORD_ZERO;
            op_r  <= fpa_pkg::OP_RECIP_SQRT_SEED;
            go_r  <= 1'b0;
        end else begin
            if (wr_opa) begin
                opa_r <= (opa_r & ~strb_mask) | (wdata_r & strb_mask);
            end
            if (wr_opb) begin
                opb_r <= (opb_r & ~strb_mask) | (wdata_r & strb_mask);
            end
            go_r <= wr_cmd & cmd_legal;
            if (wr_cmd & cmd_legal) begin
                op_r <= fpa_pkg::fpa_op_e'(cmd_code);
            end
        end
    end

    // ==========================================================
    // Datapath
    fpa_pkg::fpa_float_s       seed_res;
    fpa_pkg::fpa_arith_flags_s seed_flg;
    fpa_pkg::fpa_float_s       cmp_res;
    fpa_pkg::fpa_arith_flags_s cmp_flg;

    fpa_rsqrt_seed #(
        .SEED_W (4)
    ) u_seed (
        .operand (opa_r),
        .result  (seed_res),
        .flags   (seed_flg)
    );

    fpa_cmp_unit u_cmp (
        .op     (op_r),
        .opa    (opa_r),
        .opb    (opb_r),
        .result (cmp_res),
        .flags  (cmp_flg)
    );

    wire is_seed = (op_r == fpa_pkg::OP_RECIP_SQRT_SEED);
    wire fpa_pkg::fpa_float_s       op_res = is_seed ? seed_res : cmp_res;
    wire fpa_pkg::fpa_arith_flags_s op_flg = is_seed ? seed_flg : cmp_flg;

    // ==========================================================
    // Result, flags and sticky bits
    fpa_pkg::fpa_float_s        result_r;
    fpa_pkg::fpa_arith_flags_s  astat_r;
    fpa_pkg::fpa_sticky_flags_s stky_r;
    fpa_pkg::fpa_sticky_flags_s stky_nxt;
    fpa_pkg::fpa_sticky_flags_s stky_set;
    fpa_pkg::fpa_sticky_flags_s stky_clr;

    // RQ8: seed sticks overflow and invalid only
    // RQ16: compare ops stick invalid only
    assign stky_set = '{sticky_invalid_bit        : go_r & op_flg.alu_invalid_flag,
                        sticky_fixed_overflow_bit : 1'b0,
                        sticky_overflow_bit       : go_r & is_seed & op_flg.alu_overflow_flag,
                        sticky_underflow_bit      : 1'b0};
    // RQ17: write one to clear, a same-cycle set wins
    assign stky_clr = wr_stky ? fpa_pkg::fpa_sticky_flags_s'(wdata_r[3:0])
                              : fpa_pkg::STKY_RESET;
    assign stky_nxt = (stky_r & ~stky_clr) | stky_set;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_r <= fpa_pkg::WORD_ZERO;
            astat_r  <= fpa_pkg::ASTAT_RESET;
            stky_r   <= fpa_pkg::STKY_RESET;
        end else begin
            // RQ17: flags rewritten on every operation
            if (go_r) begin
                result_r <= op_res;
                astat_r  <= op_flg;
            end
            stky_r <= stky_nxt;
        end
    end

    // ==========================================================
    // Read channel
    logic                       arready_r;
    logic                       rvalid_r;
    logic [fpa_pkg::DATA_W-1:0] rdata_r;
    logic [1:0]                 rresp_r;

    wire ar_hs = S_AXI_ARVALID & arready_r;
    wire r_hs  = rvalid_r & S_AXI_RREADY;
    wire [fpa_pkg::ADDR_W-1:0] raddr_al = {S_AXI_ARADDR[fpa_pkg::ADDR_W-1:2], 2'b00};

    logic [fpa_pkg::DATA_W-1:0] rd_mux;
    logic                       rd_ok;
    always_comb begin
        rd_mux = fpa_pkg::WORD_ZERO;
        rd_ok  = 1'b1;
        unique case (raddr_al)
            fpa_pkg::ADDR_OPA:    rd_mux = opa_r;
            fpa_pkg::ADDR_OPB:    rd_mux = opb_r;
            fpa_pkg::ADDR_CMD:    rd_mux = {29'h0, op_r};
            fpa_pkg::ADDR_RESULT: rd_mux = result_r;
            fpa_pkg::ADDR_ASTAT:  rd_mux = {26'h0, astat_r};
            fpa_pkg::ADDR_STKY:   rd_mux = {28'h0, stky_r};
            default:              rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= fpa_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_ok ? fpa_pkg::RESP_OKAY : fpa_pkg::RESP_SLVERR;
        end else if (r_hs) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign S_AXI_AWREADY       = awready_r;
    assign S_AXI_WREADY        = wready_r;
    assign S_AXI_BVALID        = bvalid_r;
    assign S_AXI_BRESP         = bresp_r;
    assign S_AXI_ARREADY       = arready_r;
    assign S_AXI_RVALID        = rvalid_r;
    assign S_AXI_RDATA         = rdata_r;
    assign S_AXI_RRESP         = rresp_r;
    assign ARITH_STATUS_FLAGS  = astat_r;
    assign STICKY_STATUS_FLAGS = stky_r;

endmodule

// ===== verification/fpa_alu_monitor.sv
// Flag assertions for the float seed, sign-copy, min, max and clip unit.
// Assumes a bind onto fpa_alu; it watches that module's ports only.
`timescale 1ns/100ps
module fpa_alu_monitor (
    input wire logic                       CLK,
    input wire logic                       RST,
    input wire logic                       S_AXI_BVALID,
    input wire fpa_pkg::fpa_arith_flags_s  ARITH_STATUS_FLAGS,
    input wire fpa_pkg::fpa_sticky_flags_s STICKY_STATUS_FLAGS
);
    // ==========================================================
    // Flag relations; flags and sticky bits land on the same edge
    wire [5:0] af = ARITH_STATUS_FLAGS;
    wire [3:0] sf = STICKY_STATUS_FLAGS;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_carry_sign_low: assert property (af[4:3] == 2'h0)
        else $error("Carry or sign flag set");
    a_ovf_not_inv: assert property (!(af[2] && af[5]))
        else $error("Overflow together with invalid");
    a_ovf_not_zero: assert property (!(af[2] && af[0]))
        else $error("Overflow together with zero");
    a_ovf_sticks: assert property ($rose(af[2]) |-> sf[1])
        else $error("Sticky overflow not set");
    a_inv_sticks: assert property ($rose(af[5]) |-> sf[3])
        else $error("Sticky invalid not set");
    a_spare_sticky_low: assert property (!sf[2] && !sf[0])
        else $error("Unused sticky bit set");
    a_sticky_inv_cause: assert property ($rose(sf[3]) |-> af[5])
        else $error("Sticky invalid without invalid flag");
    a_flags_on_launch: assert property (!$stable(af) |-> $past(S_AXI_BVALID))
        else $error("Flags moved without a launch");
endmodule
bind fpa_alu fpa_alu_monitor mon (
    .CLK(CLK), .RST(RST), .S_AXI_BVALID(S_AXI_BVALID),
    .ARITH_STATUS_FLAGS(ARITH_STATUS_FLAGS), .STICKY_STATUS_FLAGS(STICKY_STATUS_FLAGS)
);

// ===== verification/fpa_axi_master.sv
// Bus master model standing in for the core's instruction sequencer.
// Assumes the bench calls one write or one read at a time.
`timescale 1ns/100ps
module fpa_axi_master (
    input  wire logic        clk,
    output logic [4:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [4:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // ==========================================================
    // Bus cycles; released lines carry inverted values so stale data never matches
    initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wready) {wvalid, wdata} <= {1'b0, ~d};
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (arready) {arvalid, araddr} <= {1'b0, ~a};
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule

// ===== verification/fpa_alu_tb.sv
// Self-checking bench for the float seed, sign-copy, min, max and clip unit.
// Assumes every register access goes through the bus master model.
`timescale 1ns/100ps
module fpa_alu_tb;
    logic                       clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                       arvalid, arready, rvalid, rready;
    logic [4:0]                 awaddr, araddr;
    logic [31:0]                wdata, rdata;
    logic [1:0]                 bresp, rresp;
    fpa_pkg::fpa_arith_flags_s  arith;
    fpa_pkg::fpa_sticky_flags_s sticky;
    int                         bad_count = 0;
    int                         checks_done = 0;
    fpa_alu dut (
        .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .ARITH_STATUS_FLAGS(arith), .STICKY_STATUS_FLAGS(sticky)
    );
    fpa_axi_master mst (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    // ==========================================================
    // Shared checks and bus helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) $display("Error at %0t: got %h, expected %h", $time, g, e);
        if (g !== e) bad_count++;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d,
                          input logic [1:0] x = fpa_pkg::RESP_OKAY);
        logic [1:0] r;
        mst.wr(a, d, r);
        chk({30'h0, r}, {30'h0, x});
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [31:0] e,
                          input logic [1:0] x = fpa_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        mst.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, x});
    endtask
    task automatic op_chk(input logic [2:0] op, input logic [31:0] a, b, q, input logic [5:0] f);
        wr_reg(fpa_pkg::ADDR_OPA, a);
        wr_reg(fpa_pkg::ADDR_OPB, b);
        wr_reg(fpa_pkg::ADDR_CMD, {29'h0, op});
        rd_reg(fpa_pkg::ADDR_RESULT, q);
        chk({26'h0, arith}, {26'h0, f});
    endtask
    task automatic t_bus();
        rd_reg(fpa_pkg::ADDR_STKY, 32'h0);
        wr_reg(5'h18, 32'h1, fpa_pkg::RESP_SLVERR);
        rd_reg(5'h18, 32'h0, fpa_pkg::RESP_SLVERR);
        op_chk(3'h3, 32'h3F800000, 32'hC0000000, 32'h3F800000, 6'h00);
        wr_reg(fpa_pkg::ADDR_RESULT, 32'h12345678);
        wr_reg(fpa_pkg::ADDR_CMD, 32'h5);
        rd_reg(fpa_pkg::ADDR_RESULT, 32'h3F800000);
    endtask
    task automatic t_seed();
        op_chk(3'h0, 32'h00000000, 32'h0, 32'h7F800000, 6'h04);
        chk({28'h0, sticky}, 32'h2);
        op_chk(3'h0, 32'h80000000, 32'h0, 32'hFF800000, 6'h06);
        op_chk(3'h0, 32'h7F800000, 32'h0, 32'h00000000, 6'h01);
        op_chk(3'h0, 32'h3F800000, 32'h0, 32'h3F780000, 6'h00);
        op_chk(3'h0, 32'h3E800000, 32'h0, 32'h3FF80000, 6'h00);
        op_chk(3'h0, 32'h40000000, 32'h0, 32'h3F380000, 6'h00);
        op_chk(3'h0, 32'h3F000000, 32'h0, 32'h3FB80000, 6'h00);
        op_chk(3'h0, 32'hBF800000, 32'h0, 32'hFFFFFFFF, 6'h20);
        op_chk(3'h0, 32'h7FC00000, 32'h0, 32'hFFFFFFFF, 6'h20);
        chk({28'h0, sticky}, 32'hA);
        wr_reg(fpa_pkg::ADDR_STKY, 32'h8);
        op_chk(3'h3, 32'h3F800000, 32'h0, 32'h3F800000, 6'h00);
        rd_reg(fpa_pkg::ADDR_STKY, 32'h2);
    endtask
    task automatic t_cmp();
        op_chk(3'h1, 32'h3F800000, 32'hC0000000, 32'hBF800000, 6'h02);
        op_chk(3'h1, 32'h00000001, 32'hBF800000, 32'h80000000, 6'h03);
        op_chk(3'h1, 32'h3F800000, 32'h7FC00000, 32'hFFFFFFFF, 6'h22);
        chk({28'h0, sticky}, 32'hA);
        op_chk(3'h2, 32'h00000000, 32'h80000000, 32'h80000000, 6'h03);
        op_chk(3'h3, 32'h80000000, 32'h00000000, 32'h00000000, 6'h01);
        op_chk(3'h4, 32'hC0400000, 32'h40000000, 32'hC0000000, 6'h02);
        op_chk(3'h4, 32'h3F800000, 32'hC0000000, 32'h3F800000, 6'h00);
        op_chk(3'h4, 32'h80000003, 32'h3F800000, 32'h80000000, 6'h03);
        op_chk(3'h2, 32'h7FC00000, 32'h3F800000, 32'hFFFFFFFF, 6'h22);
        wr_reg(fpa_pkg::ADDR_STKY, 32'hF);
        rd_reg(fpa_pkg::ADDR_STKY, 32'h0);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_bus();
        t_seed();
        t_cmp();
        give_verdict();
    end
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule
